// [include/dspr_pkg.sv]
// Constants, types and register map of the DSP core programming model.
// Assumes an APB master with 32-bit data and word-aligned addresses.
package dspr_pkg;

   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_X_LOW    = 6'h00;
   localparam logic [5:0] IDX_X_HIGH   = 6'h01;
   localparam logic [5:0] IDX_Y_LOW    = 6'h02;
   localparam logic [5:0] IDX_Y_HIGH   = 6'h03;
   localparam logic [5:0] IDX_ACC_BASE = 6'h04;
   localparam logic [5:0] ACC_STRIDE   = 6'h05;
   localparam logic [5:0] SUB_EXT      = 6'h00;
   localparam logic [5:0] SUB_MID      = 6'h01;
   localparam logic [5:0] SUB_LOW      = 6'h02;
   localparam logic [5:0] SUB_FULL24   = 6'h03;
   localparam logic [5:0] SUB_FULL48   = 6'h04;
   localparam logic [5:0] IDX_HI_STAGE = 6'h0e;
   localparam logic [2:0] GRP_PTR      = 3'h2;
   localparam logic [2:0] GRP_OFF      = 3'h3;
   localparam logic [2:0] GRP_MOD      = 3'h4;
   localparam logic [5:0] IDX_PC       = 6'h28;
   localparam logic [5:0] IDX_SR       = 6'h29;
   localparam logic [5:0] IDX_LC       = 6'h2a;
   localparam logic [5:0] IDX_AGU_CMD  = 6'h2b;
   localparam logic [5:0] IDX_AGU_EA   = 6'h2c;

   // Reset values
   localparam logic [15:0] MOD_RST = 16'hffff;
   localparam logic [15:0] PC_RST  = 16'h0000;
   localparam logic [15:0] SR_RST  = 16'h0300;

   // Status word fields: mode byte high, condition byte low
   localparam int unsigned MR_LSB      = 8;
   localparam int unsigned SCALE_LSB   = 10;
   localparam int unsigned LOOP_BIT    = 15;
   localparam int unsigned LIMIT_BIT   = 6;
   localparam logic [7:0]  EXC_MASK    = 8'h03;
   localparam logic [1:0]  SCALE_NONE  = 2'h0;
   localparam logic [1:0]  SCALE_DOWN  = 2'h1;
   localparam logic [1:0]  SCALE_UP    = 2'h2;

   // Address update command fields and modes
   localparam int unsigned CMD_MODE_LSB = 3;
   localparam int unsigned CMD_PRE_BIT  = 5;
   localparam logic [1:0]  UPD_INC      = 2'h0;
   localparam logic [1:0]  UPD_DEC      = 2'h1;
   localparam logic [1:0]  UPD_ADD_OFF  = 2'h2;
   localparam logic [1:0]  UPD_SUB_OFF  = 2'h3;
   localparam logic [15:0] MOD_REVERSE  = 16'h0000;
   localparam logic [15:0] MOD_LINEAR   = 16'hffff;

   // Limiting constants
   localparam logic [23:0] LIM_POS = 24'h7fffff;
   localparam logic [23:0] LIM_NEG = 24'h800000;

   typedef enum logic [3:0] {
      OP_NONE, OP_JSR, OP_DO_START, OP_DO_END, OP_LOOP_EXIT_INSTR, OP_RTI,
      OP_SWI, OP_EXC, OP_ORI_MR, OP_IMMEDIATE_AND_INSTR_MR, OP_ORI_CCR, OP_IMMEDIATE_AND_INSTR_CCR,
      OP_ALU
   } dspr_op_t;

   typedef struct packed {
      dspr_op_t    op;
      logic [15:0] arg;
      logic [7:0]  condition_code_byte;
   } dspr_ev_t;

   typedef struct packed {
      logic [15:0] pc;
      logic [15:0] sr;
      logic [15:0] lc;
      logic        with_lc;
   } dspr_frame_t;

endpackage : dspr_pkg

// [design/dspr_regs.sv]
// Programming model register set of a 24-bit DSP core, on APB.
// Assumes the core sequencer drives one event per cycle and presents
// the top stack frame together with every popping event.
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module dspr_regs (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic [11:0]         paddr,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire dspr_pkg::dspr_ev_t  core_ev,
   input  wire logic                fetch_adv,
   input  wire dspr_pkg::dspr_frame_t stk_top,
   output logic                     stk_push,
   output dspr_pkg::dspr_frame_t    stk_frame
);

   ////////////////////////////////////////////////////////////////////
   // Functions

   function automatic logic [15:0] bit_rev(input logic [15:0] v);
      logic [15:0] o;
      o = 16'h0000;
      for (int i = 0; i < 16; i++) begin
         o[i] = v[15-i];
      end
      return o;
   endfunction : bit_rev

   // Next pointer value for one update step
   function automatic logic [15:0] agu_next(
      input logic [15:0] r,
      input logic [15:0] n,
      input logic [15:0] m,
      input logic [1:0]  mode);
      logic [15:0] step;
      logic [15:0] mask;
      logic [17:0] rel;
      logic [17:0] span;
      step = 16'h0000;
      mask = m;
      rel  = 18'h00000;
      span = {2'b00, m} + 18'h00001;
      case (mode)
         dspr_pkg::UPD_INC:     step = 16'h0001;
         dspr_pkg::UPD_DEC:     step = 16'hffff;
         dspr_pkg::UPD_ADD_OFF: step = n;
         default:               step = 16'h0000 - n;
      endcase
      for (int i = 0; i < 4; i++) begin
         mask = mask | (mask >> (1 << i));
      end
      if (m == dspr_pkg::MOD_REVERSE) begin
         return bit_rev(bit_rev(r) + bit_rev(step));
      end else if (m == dspr_pkg::MOD_LINEAR) begin
         return r + step;
      end else begin
         // Modulo window holds only steps up to the modulus in size
         rel = {2'b00, r & mask} + {{2{step[15]}}, step};
         if (rel[17]) begin
            rel = rel + span;
         end else if (rel > {2'b00, m}) begin
            rel = rel - span;
         end
         return (r & ~mask) | rel[15:0];
      end
   endfunction : agu_next

   // Scaled, limited 24-bit move of a whole accumulator; bit 24 = limit
   function automatic logic [24:0] acc_move(
      input logic [55:0] acc,
      input logic [1:0]  scale);
      logic [55:0] sh;
      logic        ovf;
      case (scale)
         dspr_pkg::SCALE_DOWN: sh = {acc[55], acc[55:1]};
         dspr_pkg::SCALE_UP:   sh = {acc[54:0], 1'b0};
         default:              sh = acc;
      endcase
      ovf = !((&sh[55:47]) || !(|sh[55:47]));
      if (ovf) begin
         return {1'b1, acc[55] ? dspr_pkg::LIM_NEG : dspr_pkg::LIM_POS};
      end
      return {1'b0, sh[47:24]};
   endfunction : acc_move

   ////////////////////////////////////////////////////////////////////
   // Bus decode

   logic [23:0] alu_in_r [4];
   logic [55:0] acc_r    [2];
   logic [23:0] hi_stage_r;
   logic [15:0] ptr_r    [8];
   logic [15:0] off_r    [8];
   logic [15:0] mod_r    [8];
   logic [15:0] pc_r;
   logic [15:0] sr_r;
   logic [15:0] sr_nxt;
   logic [15:0] lc_r;
   logic [15:0] ea_r;
   logic [31:0] prdata_r;
   logic        err_r;
   logic        push_r;
   dspr_pkg::dspr_frame_t frame_r;
   logic [31:0] rd_mux;
   logic        mapped;

   wire [5:0]  idx      = paddr[7:2];
   wire [2:0]  grp      = idx[5:3];
   wire [2:0]  sel      = idx[2:0];
   wire        hi_zero  = (paddr[11:8] == 4'h0);
   wire        setup    = psel & ~penable;
   wire        access   = psel & penable;
   // Upper address bits set alias nothing: such writes are dropped
   wire        wr       = access & pwrite & hi_zero;
   wire        rd_done  = access & ~pwrite & hi_zero;
   wire [1:0]  scale    = sr_r[dspr_pkg::SCALE_LSB +: 2];
   wire [24:0] move_a   = acc_move(acc_r[0], scale);
   wire [24:0] move_b   = acc_move(acc_r[1], scale);
   wire [5:0]  full24_a = dspr_pkg::IDX_ACC_BASE + dspr_pkg::SUB_FULL24;
   wire [5:0]  full24_b = full24_a + dspr_pkg::ACC_STRIDE;
   wire        lim_hit  = rd_done & ((idx == full24_a & move_a[24]) |
                                     (idx == full24_b & move_b[24]));
   wire        cmd_wr   = wr & (idx == dspr_pkg::IDX_AGU_CMD);
   wire [2:0]  cmd_ptr  = pwdata[2:0];
   wire [1:0]  cmd_mode = pwdata[dspr_pkg::CMD_MODE_LSB +: 2];
   wire        cmd_pre  = pwdata[dspr_pkg::CMD_PRE_BIT];
   wire [15:0] upd_val  = agu_next(ptr_r[cmd_ptr], off_r[cmd_ptr],
                                   mod_r[cmd_ptr], cmd_mode);
   wire        op_push  = (core_ev.op == dspr_pkg::OP_JSR) |
                          (core_ev.op == dspr_pkg::OP_DO_START);
   wire        op_lcpop = (core_ev.op == dspr_pkg::OP_DO_END) |
                          (core_ev.op == dspr_pkg::OP_LOOP_EXIT_INSTR);

   assign pready  = access;
   assign pslverr = access & err_r;
   assign prdata  = prdata_r;

   always_comb begin
      rd_mux = 32'h00000000;
      mapped = hi_zero;
      if (idx < dspr_pkg::IDX_ACC_BASE) begin
         rd_mux[23:0] = alu_in_r[idx[1:0]];
      end else if (idx < dspr_pkg::IDX_HI_STAGE) begin
         case (idx)
            6'h04: rd_mux[7:0]  = acc_r[0][55:48];
            6'h05: rd_mux[23:0] = acc_r[0][47:24];
            6'h06: rd_mux[23:0] = acc_r[0][23:0];
            6'h07: rd_mux[23:0] = move_a[23:0];
            6'h09: rd_mux[7:0]  = acc_r[1][55:48];
            6'h0a: rd_mux[23:0] = acc_r[1][47:24];
            6'h0b: rd_mux[23:0] = acc_r[1][23:0];
            6'h0c: rd_mux[23:0] = move_b[23:0];
            default: rd_mux = 32'h00000000;
         endcase
      end else if (idx == dspr_pkg::IDX_HI_STAGE) begin
         rd_mux[23:0] = hi_stage_r;
      end else if (grp == dspr_pkg::GRP_PTR) begin
         rd_mux[15:0] = ptr_r[sel];
      end else if (grp == dspr_pkg::GRP_OFF) begin
         rd_mux[15:0] = off_r[sel];
      end else if (grp == dspr_pkg::GRP_MOD) begin
         rd_mux[15:0] = mod_r[sel];
      end else begin
         case (idx)
            dspr_pkg::IDX_PC:      rd_mux[15:0] = pc_r;
            dspr_pkg::IDX_SR:      rd_mux[15:0] = sr_r;
            dspr_pkg::IDX_LC:      rd_mux[15:0] = lc_r;
            dspr_pkg::IDX_AGU_CMD: rd_mux = 32'h00000000;
            dspr_pkg::IDX_AGU_EA:  rd_mux[15:0] = ea_r;
            default:               mapped = 1'b0;
         endcase
      end
   end

   // Read data captured in setup so the access phase needs no wait
   always_ff @(posedge clk) begin
      if (rst) begin
         prdata_r <= 32'h00000000;
         err_r    <= 1'b0;
      end else if (setup) begin
         prdata_r <= mapped ? rd_mux : 32'h00000000;
         err_r    <= ~mapped;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Data ALU registers

   for (genvar g = 0; g < 4; g++) begin : g_alu_in
      always_ff @(posedge clk) begin
         if (rst) begin
            alu_in_r[g] <= 24'h000000;
         end else if (wr & idx == 6'(g)) begin
            alu_in_r[g] <= pwdata[23:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         hi_stage_r <= 24'h000000;
      end else if (wr & idx == dspr_pkg::IDX_HI_STAGE) begin
         hi_stage_r <= pwdata[23:0];
      end
   end

   for (genvar g = 0; g < 2; g++) begin : g_acc
      wire [5:0] base = dspr_pkg::IDX_ACC_BASE + 6'(g * 5);
      wire [5:0] sub  = idx - base;
      wire       hit  = wr & (idx >= base) &
                        (sub <= dspr_pkg::SUB_FULL48);
      always_ff @(posedge clk) begin
         if (rst) begin
            acc_r[g] <= 56'h00000000000000;
         end else if (hit) begin
            case (sub)
               dspr_pkg::SUB_EXT:    acc_r[g][55:48] <= pwdata[7:0];
               dspr_pkg::SUB_MID:    acc_r[g][47:24] <= pwdata[23:0];
               dspr_pkg::SUB_LOW:    acc_r[g][23:0]  <= pwdata[23:0];
               dspr_pkg::SUB_FULL24: acc_r[g] <= {{8{pwdata[23]}},
                  pwdata[23:0], 24'h000000};
               default:              acc_r[g] <= {{8{hi_stage_r[23]}},
                  hi_stage_r, pwdata[23:0]};
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Address generation registers

   for (genvar g = 0; g < 8; g++) begin : g_agu
      always_ff @(posedge clk) begin
         if (rst) begin
            ptr_r[g] <= 16'h0000;
            off_r[g] <= 16'h0000;
            mod_r[g] <= dspr_pkg::MOD_RST;
         end else begin
            if (cmd_wr & cmd_ptr == 3'(g)) begin
               ptr_r[g] <= upd_val;
            end else if (wr & grp == dspr_pkg::GRP_PTR & sel == 3'(g)) begin
               ptr_r[g] <= pwdata[15:0];
            end
            if (wr & grp == dspr_pkg::GRP_OFF & sel == 3'(g)) begin
               off_r[g] <= pwdata[15:0];
            end
            if (wr & grp == dspr_pkg::GRP_MOD & sel == 3'(g)) begin
               mod_r[g] <= pwdata[15:0];
            end
         end
      end
   end

   // Address used by the last update: new value if pre, old if post
   always_ff @(posedge clk) begin
      if (rst) begin
         ea_r <= 16'h0000;
      end else if (cmd_wr) begin
         ea_r <= cmd_pre ? upd_val : ptr_r[cmd_ptr];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Program control registers

   always_comb begin
      sr_nxt = sr_r;
      if (wr & idx == dspr_pkg::IDX_SR) begin
         sr_nxt = pwdata[15:0];
      end
      case (core_ev.op)
         dspr_pkg::OP_RTI:      sr_nxt = stk_top.sr;
         dspr_pkg::OP_SWI,
         dspr_pkg::OP_EXC:      sr_nxt[15:8] = sr_r[15:8] | dspr_pkg::EXC_MASK;
         dspr_pkg::OP_DO_START: sr_nxt[dspr_pkg::LOOP_BIT] = 1'b1;
         dspr_pkg::OP_DO_END,
         dspr_pkg::OP_LOOP_EXIT_INSTR:    sr_nxt[15:8] = stk_top.sr[15:8];
         dspr_pkg::OP_ORI_MR:   sr_nxt[15:8] = sr_r[15:8] | core_ev.arg[7:0];
         dspr_pkg::OP_IMMEDIATE_AND_INSTR_MR:  sr_nxt[15:8] = sr_r[15:8] & core_ev.arg[7:0];
         dspr_pkg::OP_ORI_CCR:  sr_nxt[7:0]  = sr_r[7:0] | core_ev.arg[7:0];
         dspr_pkg::OP_IMMEDIATE_AND_INSTR_CCR: sr_nxt[7:0]  = sr_r[7:0] & core_ev.arg[7:0];
         dspr_pkg::OP_ALU:      sr_nxt[7:0]  = core_ev.condition_code_byte;
         default:               sr_nxt = sr_nxt;
      endcase
      // Limiting is the one move that marks the condition byte
      if (lim_hit) begin
         sr_nxt[dspr_pkg::LIMIT_BIT] = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sr_r    <= dspr_pkg::SR_RST;
         pc_r    <= dspr_pkg::PC_RST;
         lc_r    <= 16'h0000;
         push_r  <= 1'b0;
         frame_r <= '0;
      end else begin
         sr_r   <= sr_nxt;
         push_r <= op_push;
         if (op_push) begin
            frame_r <= {pc_r, sr_r, lc_r,
                        core_ev.op == dspr_pkg::OP_DO_START};
         end
         // Program counter ignores bus writes
         if (core_ev.op == dspr_pkg::OP_JSR) begin
            pc_r <= core_ev.arg;
         end else if (core_ev.op == dspr_pkg::OP_RTI) begin
            pc_r <= stk_top.pc;
         end else if (fetch_adv) begin
            pc_r <= pc_r + 16'h0001;
         end
         if (core_ev.op == dspr_pkg::OP_DO_START) begin
            lc_r <= core_ev.arg;
         end else if (op_lcpop) begin
            lc_r <= stk_top.lc;
         end else if (wr & idx == dspr_pkg::IDX_LC) begin
            lc_r <= pwdata[15:0];
         end
      end
   end

   assign stk_push  = push_r;
   assign stk_frame = frame_r;

   ////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_rd_full_a;
      setup & hi_zero & ~pwrite & idx == full24_a & ~move_a[24];
   endsequence

   sequence s_acc_wr(logic [5:0] a);
      wr & idx == a;
   endsequence

   a_mod_reset_ones: assert property (
      @(posedge clk) disable iff (1'b0) rst |=>
      mod_r[0] == dspr_pkg::MOD_RST && mod_r[7] == dspr_pkg::MOD_RST)
      else $error("modifier not all ones after reset");

   a_full24_fill: assert property (s_acc_wr(6'h07) |=>
      acc_r[0][23:0] == 24'h000000 &&
      acc_r[0][47:24] == $past(pwdata[23:0]) &&
      acc_r[0][55:48] == {8{$past(pwdata[23])}})
      else $error("full 24-bit write not extended or filled");

   a_sub_write_only: assert property (s_acc_wr(6'h05) |=>
      $stable(acc_r[0][55:48]) && $stable(acc_r[0][23:0]))
      else $error("middle word write disturbed other words");

   a_raw_read: assert property (
      setup & hi_zero & ~pwrite & idx == 6'h05 |=>
      prdata[23:0] == acc_r[0][47:24])
      else $error("sub-register read not raw");

   a_limit_value: assert property (
      setup & hi_zero & ~pwrite & idx == full24_a & move_a[24] |=>
      prdata[23:0] == (acc_r[0][55] ? dspr_pkg::LIM_NEG :
      dspr_pkg::LIM_POS))
      else $error("limiting constant wrong");

   a_limit_keeps: assert property (
      rd_done & idx == full24_a & core_ev.op == dspr_pkg::OP_NONE |=>
      $stable(acc_r[0]))
      else $error("accumulator changed by a read");

   a_limit_flag: assert property (
      lim_hit |=> sr_r[dspr_pkg::LIMIT_BIT])
      else $error("limit flag not set");

   // Expected value from raw bits, independent of the move function
   a_nolim_scaled: assert property (
      s_rd_full_a ##1 penable |->
      prdata[23:0] == ($past(scale) == dspr_pkg::SCALE_UP ?
                       $past(acc_r[0][46:23]) :
                       $past(scale) == dspr_pkg::SCALE_DOWN ?
                       $past(acc_r[0][48:25]) : $past(acc_r[0][47:24])))
      else $error("scaled read value wrong");

   a_ccr_stable: assert property (
      core_ev.op == dspr_pkg::OP_NONE & ~lim_hit &
      ~(wr & idx == dspr_pkg::IDX_SR) |=> $stable(sr_r[7:0]))
      else $error("condition byte changed by a plain move");

   a_pc_no_write: assert property (
      wr & idx == dspr_pkg::IDX_PC & core_ev.op == dspr_pkg::OP_NONE &
      ~fetch_adv |=> $stable(pc_r))
      else $error("program counter written by the bus");

   a_jsr_push: assert property (
      core_ev.op == dspr_pkg::OP_JSR |=>
      stk_push && stk_frame.pc == $past(pc_r) &&
      stk_frame.sr == $past(sr_r) && pc_r == $past(core_ev.arg))
      else $error("jump did not push counter and status");

   a_do_lc: assert property (
      core_ev.op == dspr_pkg::OP_DO_START |=>
      stk_frame.lc == $past(lc_r) && lc_r == $past(core_ev.arg) &&
      stk_frame.with_lc)
      else $error("loop start did not stack the loop count");

   a_linear_inc: assert property (
      cmd_wr & cmd_mode == dspr_pkg::UPD_INC &
      mod_r[cmd_ptr] == dspr_pkg::MOD_LINEAR |=>
      ptr_r[$past(cmd_ptr)] == $past(ptr_r[cmd_ptr]) + 16'h0001)
      else $error("linear increment wrong");

endmodule : dspr_regs

// [bench/tb_top.sv]
// Self-checking bench for the DSP core register set, reached over APB.
// Assumes the bench stands in for the core sequencer and system stack.
`timescale 1ns/1ns
module tb_top;
   logic                  clk;
   logic                  rst;
   logic [11:0]           paddr;
   logic                  psel;
   logic                  penable;
   logic                  pwrite;
   logic [31:0]           pwdata;
   logic [31:0]           prdata;
   logic                  pready;
   logic                  pslverr;
   dspr_pkg::dspr_ev_t    core_ev;
   logic                  fetch_adv;
   dspr_pkg::dspr_frame_t stk_top;
   logic                  stk_push;
   dspr_pkg::dspr_frame_t stk_frame;
   logic [31:0]           rdat;
   logic                  rerr;
   int                    failures = 0;
   int                    n_tests = 0;
   int                    cycles = 0;

   dspr_regs u_dut (
      .clk       (clk),
      .rst       (rst),
      .paddr     (paddr),
      .psel      (psel),
      .penable   (penable),
      .pwrite    (pwrite),
      .pwdata    (pwdata),
      .prdata    (prdata),
      .pready    (pready),
      .pslverr   (pslverr),
      .core_ev   (core_ev),
      .fetch_adv (fetch_adv),
      .stk_top   (stk_top),
      .stk_push  (stk_push),
      .stk_frame (stk_frame)
   );

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask : chk

   task stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test

   // Request held until pready is seen at a rising edge
   task apb(input logic w, input logic [5:0] idx, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {4'h0, idx, 2'b00};
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wr(input logic [5:0] idx, input logic [31:0] d);
      apb(1'b1, idx, d);
   endtask : wr

   task rdc(input logic [5:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk(rdat, exp);
   endtask : rdc

   // One core event, sampled settled just after its taking edge
   task ev(input dspr_pkg::dspr_op_t op, input logic [15:0] a,
           input logic [7:0] cc);
      @(posedge clk);
      core_ev <= '{op, a, cc};
      @(posedge clk);
      core_ev <= '{dspr_pkg::OP_NONE, 16'h0000, 8'h00};
      #1;
   endtask : ev

   // Hang guard, well above the length of the sequence
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         stop_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      fetch_adv = 1'b0;
      core_ev = '{dspr_pkg::OP_NONE, 16'h0000, 8'h00};
      stk_top = '0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++) rdc(6'(6'h20 + i), 32'hffff);
      rdc(dspr_pkg::IDX_SR, 32'h0300);
      // Program control and stack traffic
      wr(dspr_pkg::IDX_PC, 32'h1234);
      rdc(dspr_pkg::IDX_PC, 32'h0);
      @(posedge clk);
      fetch_adv <= 1'b1;
      @(posedge clk);
      fetch_adv <= 1'b0;
      rdc(dspr_pkg::IDX_PC, 32'h1);
      ev(dspr_pkg::OP_JSR, 16'h0200, 8'h00);
      chk(32'(stk_push), 32'h1);
      chk(32'(stk_frame.pc), 32'h1);
      chk(32'(stk_frame.sr), 32'h0300);
      rdc(dspr_pkg::IDX_PC, 32'h0200);
      wr(dspr_pkg::IDX_LC, 32'h7);
      ev(dspr_pkg::OP_DO_START, 16'h0005, 8'h00);
      chk({15'h0, stk_frame.with_lc, stk_frame.lc}, 32'h10007);
      chk(32'(stk_frame.pc), 32'h0200);
      rdc(dspr_pkg::IDX_LC, 32'h5);
      rdc(dspr_pkg::IDX_SR, 32'h8300);
      stk_top <= '{16'h0123, 16'h0300, 16'h0007, 1'b1};
      ev(dspr_pkg::OP_DO_END, 16'h0000, 8'h00);
      rdc(dspr_pkg::IDX_SR, 32'h0300);
      rdc(dspr_pkg::IDX_LC, 32'h7);
      ev(dspr_pkg::OP_ALU, 16'h0000, 8'h15);
      rdc(dspr_pkg::IDX_SR, 32'h0315);
      stk_top <= '{16'h0123, 16'h0400, 16'h0000, 1'b0};
      ev(dspr_pkg::OP_RTI, 16'h0000, 8'h00);
      rdc(dspr_pkg::IDX_PC, 32'h0123);
      ev(dspr_pkg::OP_SWI, 16'h0000, 8'h00);
      rdc(dspr_pkg::IDX_SR, 32'h0700);
      ev(dspr_pkg::OP_ORI_MR, 16'h0030, 8'h00);
      rdc(dspr_pkg::IDX_SR, 32'h3700);
      ev(dspr_pkg::OP_IMMEDIATE_AND_INSTR_MR, 16'h0004, 8'h00);
      ev(dspr_pkg::OP_EXC, 16'h0000, 8'h00);
      rdc(dspr_pkg::IDX_SR, 32'h0700);
      ev(dspr_pkg::OP_ORI_CCR, 16'h0081, 8'h00);
      ev(dspr_pkg::OP_IMMEDIATE_AND_INSTR_CCR, 16'h0003, 8'h00);
      rdc(dspr_pkg::IDX_SR, 32'h0701);
      ev(dspr_pkg::OP_LOOP_EXIT_INSTR, 16'h0000, 8'h00);
      rdc(dspr_pkg::IDX_SR, 32'h0401);
      rdc(dspr_pkg::IDX_LC, 32'h0);
      // Input registers and accumulators
      for (int i = 0; i < 4; i++) wr(6'(i), 32'h0a0000 + i);
      for (int i = 0; i < 4; i++) rdc(6'(i), 32'h0a0000 + i);
      wr(6'h06, 32'h555555);
      wr(6'h07, 32'h800000);
      rdc(6'h04, 32'hff);
      rdc(6'h05, 32'h800000);
      rdc(6'h06, 32'h0);
      wr(6'h04, 32'h12);
      rdc(6'h04, 32'h12);
      rdc(6'h05, 32'h800000);
      wr(dspr_pkg::IDX_HI_STAGE, 32'h123456);
      wr(6'h08, 32'habcdef);
      rdc(6'h04, 32'h0);
      rdc(6'h05, 32'h123456);
      rdc(6'h06, 32'habcdef);
      wr(dspr_pkg::IDX_SR, 32'h0800);
      rdc(6'h07, 32'h2468ad);
      rdc(6'h05, 32'h123456);
      rdc(dspr_pkg::IDX_SR, 32'h0800);
      wr(6'h05, 32'h400000);
      wr(6'h06, 32'h0);
      rdc(6'h07, 32'h7fffff);
      rdc(6'h05, 32'h400000);
      rdc(dspr_pkg::IDX_SR, 32'h0840);
      wr(dspr_pkg::IDX_SR, 32'h0400);
      rdc(6'h07, 32'h200000);
      wr(dspr_pkg::IDX_SR, 32'h0);
      rdc(6'h07, 32'h400000);
      wr(6'h0c, 32'ha00000);
      wr(dspr_pkg::IDX_SR, 32'h0800);
      rdc(6'h0c, 32'h800000);
      rdc(6'h0a, 32'ha00000);
      // Address generation
      for (int i = 0; i < 8; i++) begin
         wr(6'(6'h10 + i), 32'h1000 + i);
         wr(6'(6'h18 + i), 32'h2000 + i);
      end
      for (int i = 0; i < 8; i++) begin
         rdc(6'(6'h10 + i), 32'h1000 + i);
         rdc(6'(6'h18 + i), 32'h2000 + i);
      end
      wr(6'h10, 32'h10);
      wr(6'h18, 32'h4);
      wr(dspr_pkg::IDX_AGU_CMD, 32'h10);
      rdc(dspr_pkg::IDX_AGU_EA, 32'h10);
      rdc(6'h10, 32'h14);
      rdc(6'h18, 32'h4);
      wr(dspr_pkg::IDX_AGU_CMD, 32'h2b);
      rdc(dspr_pkg::IDX_AGU_EA, 32'h1002);
      wr(dspr_pkg::IDX_AGU_CMD, 32'h1c);
      rdc(6'h14, 32'hf000);
      wr(6'h21, 32'h7);
      wr(6'h11, 32'h27);
      wr(dspr_pkg::IDX_AGU_CMD, 32'h21);
      rdc(6'h11, 32'h20);
      wr(6'h22, 32'h0);
      wr(6'h12, 32'h8);
      wr(6'h1a, 32'h8);
      wr(dspr_pkg::IDX_AGU_CMD, 32'h12);
      rdc(6'h12, 32'h4);
      wr(dspr_pkg::IDX_AGU_CMD, 32'h05);
      rdc(dspr_pkg::IDX_AGU_EA, 32'h1005);
      rdc(6'h15, 32'h1006);
      // Unmapped place: refused, reads zero
      wr(6'h30, 32'h5);
      chk(32'(rerr), 32'h1);
      rdc(6'h30, 32'h0);
      chk(32'(rerr), 32'h1);
      stop_test();
   end
endmodule : tb_top
